// ### core/adc_ctrl_pkg.sv
// adc_ctrl_pkg: register map, field positions and timing counts of the converter control block
// assumes a 32-bit apb bus with one aligned word per register
package adc_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFS_RESULT_A    = 8'h04;
   localparam logic [7:0] OFS_RESULT_B    = 8'h08;
   localparam logic [7:0] OFS_RESULT_C    = 8'h0C;
   localparam logic [7:0] OFS_RESULT_D    = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
   // control/status field positions
   localparam int BIT_DONE  = 7;
   localparam int BIT_IE    = 6;
   localparam int BIT_GO    = 5;
   localparam int BIT_SWEEP = 4;
   localparam int BIT_SPEED = 3;
   localparam int CH_HI     = 2;
   localparam int CH_LO     = 0;
   localparam logic [7:0] CSR_RESET = 8'h00;
   // result placement
   localparam int RES_W  = 10;
   localparam int RES_LO = 6;
   localparam int NUM_IN = 4;
   // conversion lengths in states (system clock cycles)
   localparam logic [7:0] STATES_SLOW_FIRST  = 8'd134;
   localparam logic [7:0] STATES_FAST_FIRST  = 8'd70;
   localparam logic [7:0] STATES_SLOW_REPEAT = 8'd128;
   localparam logic [7:0] STATES_FAST_REPEAT = 8'd66;
endpackage

// ### core/adc_step_timer.sv
// adc_step_timer: counts the states of one conversion and pulses when it ends
// assumes a load pulse starts a fresh count; abort stops it at once
`timescale 1ns/1ns
module adc_step_timer #(
   parameter int CNT_W = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_length,
   input  wire logic             i_abort,
   output logic                  o_busy,
   output logic                  o_done
);
   initial begin
      if (CNT_W < 8) $error("adc_step_timer: CNT_W too small");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             busy;
      logic             done;
   } tmr_state_t;

   tmr_state_t s_reg;
   tmr_state_t s_next;

   always_comb begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      // a fresh load wins over a pending abort so a quick restart is not lost
      if (i_load) begin
         s_next.busy = 1'b1;
         s_next.cnt  = i_length - CNT_W'(1);
      end else if (i_abort) begin
         s_next.busy = 1'b0;
      end else if (s_reg.busy) begin
         if (s_reg.cnt == CNT_W'(1)) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_busy = s_reg.busy;
   assign o_done = s_reg.done;
endmodule // adc_step_timer

// ### core/adc_control_status_sequencer.sv
// adc_control_status_sequencer: control/status register, channel sequencing and
// result capture of a four-input successive-approximation converter, apb slave.
// assumes the converter core presents a 10-bit code on i_conv_data that is valid
// when the conversion timer expires; i_standby is synchronous to i_clk.
`timescale 1ns/1ns
module adc_control_status_sequencer (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [9:0]  i_conv_data,
   input  wire logic        i_standby,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [1:0]       o_mux_select,
   output logic             o_sample,
   output logic             o_conversion_done_irq,
   output logic             o_irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic                                  done_flag;
      logic                                  done_seen;
      logic                                  irq_en;
      logic                                  go;
      logic                                  sweep;
      logic                                  speed;
      logic [2:0]                            chan;
      logic [1:0]                            cur;
      logic                                  first;
      logic [adc_ctrl_pkg::NUM_IN*adc_ctrl_pkg::RES_W-1:0] results;
      logic [1:0]                            ev_status;
      logic [1:0]                            ev_mask;
      logic [31:0]                           rdata;
      logic                                  sample;
   } seq_state_t;

   seq_state_t s_reg;
   seq_state_t s_next;

   logic       apb_setup;
   logic       apb_wr;
   logic       apb_rd;
   logic       tmr_load;
   logic [7:0] tmr_len;
   logic       tmr_busy;
   logic       tmr_done;
   logic       tmr_abort;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // last input of the selection: single mode picks one, sweep picks 0 through it
   function automatic logic [1:0] last_input(input logic [2:0] code);
      return code[1:0];
   endfunction

   // conversion length from speed bit and first/repeat position
   function automatic logic [7:0] conv_len(input logic fast, input logic rep);
      if (rep) begin
         return fast ? adc_ctrl_pkg::STATES_FAST_REPEAT : adc_ctrl_pkg::STATES_SLOW_REPEAT;
      end
      return fast ? adc_ctrl_pkg::STATES_FAST_FIRST : adc_ctrl_pkg::STATES_SLOW_FIRST;
   endfunction

   function automatic logic [7:0] csr_image(input seq_state_t s);
      logic [7:0] v;
      v = adc_ctrl_pkg::CSR_RESET;
      v[adc_ctrl_pkg::BIT_DONE]                    = s.done_flag;
      v[adc_ctrl_pkg::BIT_IE]                      = s.irq_en;
      v[adc_ctrl_pkg::BIT_GO]                      = s.go;
      v[adc_ctrl_pkg::BIT_SWEEP]                   = s.sweep;
      v[adc_ctrl_pkg::BIT_SPEED]                   = s.speed;
      v[adc_ctrl_pkg::CH_HI:adc_ctrl_pkg::CH_LO]   = s.chan;
      return v;
   endfunction

   function automatic logic [31:0] result_word(input seq_state_t s, input int idx);
      logic [31:0] w;
      w = '0;
      w[adc_ctrl_pkg::RES_LO +: adc_ctrl_pkg::RES_W] =
         s.results[idx*adc_ctrl_pkg::RES_W +: adc_ctrl_pkg::RES_W];
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode: zero wait states, unmapped addresses answer with pslverr

   assign apb_setup = i_psel && !i_penable;
   assign apb_wr    = i_psel && i_penable && i_pwrite;
   assign apb_rd    = i_psel && i_penable && !i_pwrite;

   function automatic logic addr_ok(input logic [7:0] a);
      return (a == adc_ctrl_pkg::OFS_CTRL_STATUS) || (a == adc_ctrl_pkg::OFS_RESULT_A) ||
             (a == adc_ctrl_pkg::OFS_RESULT_B) || (a == adc_ctrl_pkg::OFS_RESULT_C) ||
             (a == adc_ctrl_pkg::OFS_RESULT_D) || (a == adc_ctrl_pkg::OFS_IRQ_STATUS) ||
             (a == adc_ctrl_pkg::OFS_IRQ_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic       start;
      logic       stop;
      logic       end_conv;
      logic       last;
      logic       set_done;
      logic       go_wr;
      logic [7:0] wb;
      start    = 1'b0;
      stop     = 1'b0;
      end_conv = 1'b0;
      last     = 1'b0;
      set_done = 1'b0;
      go_wr    = 1'b0;
      wb       = i_pwdata[7:0];
      s_next   = s_reg;
      s_next.sample = 1'b0;
      tmr_load = 1'b0;
      tmr_len  = conv_len(s_reg.speed, 1'b0);

      // read data is captured during the setup phase so it stands in the access phase
      if (apb_setup && !i_pwrite) begin
         case (i_paddr)
            adc_ctrl_pkg::OFS_CTRL_STATUS: s_next.rdata = {24'h00_0000, csr_image(s_reg)};
            adc_ctrl_pkg::OFS_RESULT_A:    s_next.rdata = result_word(s_reg, 0);
            adc_ctrl_pkg::OFS_RESULT_B:    s_next.rdata = result_word(s_reg, 1);
            adc_ctrl_pkg::OFS_RESULT_C:    s_next.rdata = result_word(s_reg, 2);
            adc_ctrl_pkg::OFS_RESULT_D:    s_next.rdata = result_word(s_reg, 3);
            adc_ctrl_pkg::OFS_IRQ_STATUS:  s_next.rdata = {30'h0000_0000, s_reg.ev_status};
            adc_ctrl_pkg::OFS_IRQ_MASK:    s_next.rdata = {30'h0000_0000, s_reg.ev_mask};
            default:                       s_next.rdata = 32'h0000_0000;
         endcase
      end

      // only a completed read whose returned image shows the flag at one arms the clear
      if (apb_rd && i_paddr == adc_ctrl_pkg::OFS_CTRL_STATUS &&
          s_reg.rdata[adc_ctrl_pkg::BIT_DONE] && s_reg.done_flag) begin
         s_next.done_seen = 1'b1;
      end

      if (apb_wr && i_paddr == adc_ctrl_pkg::OFS_CTRL_STATUS) begin
         s_next.irq_en = wb[adc_ctrl_pkg::BIT_IE];
         s_next.sweep  = wb[adc_ctrl_pkg::BIT_SWEEP];
         s_next.speed  = wb[adc_ctrl_pkg::BIT_SPEED];
         s_next.chan   = wb[adc_ctrl_pkg::CH_HI:adc_ctrl_pkg::CH_LO];
         s_next.go     = wb[adc_ctrl_pkg::BIT_GO];
         go_wr         = 1'b1;
         if (wb[adc_ctrl_pkg::BIT_GO] && !s_reg.go) begin
            start = 1'b1;
         end
         if (!wb[adc_ctrl_pkg::BIT_GO]) begin
            stop = 1'b1;
         end
         // writing one leaves the flag alone; zero clears only after a read saw one
         if (!wb[adc_ctrl_pkg::BIT_DONE] && s_reg.done_seen) begin
            s_next.done_flag = 1'b0;
            s_next.done_seen = 1'b0;
         end
      end
      if (apb_wr && i_paddr == adc_ctrl_pkg::OFS_IRQ_STATUS) begin
         s_next.ev_status = s_reg.ev_status & ~i_pwdata[1:0];
      end
      if (apb_wr && i_paddr == adc_ctrl_pkg::OFS_IRQ_MASK) begin
         s_next.ev_mask = i_pwdata[1:0];
      end

      if (i_standby) begin
         s_next.go = 1'b0;
         stop      = 1'b1;
      end

      // conversion sequencing
      if (tmr_done && s_reg.go && !stop) begin
         end_conv = 1'b1;
         s_next.results[s_reg.cur*adc_ctrl_pkg::RES_W +: adc_ctrl_pkg::RES_W] = i_conv_data;
         last = !s_reg.sweep || (s_reg.cur == last_input(s_reg.chan));
         if (!s_reg.sweep) begin
            set_done = 1'b1;
            if (!go_wr) begin
               s_next.go = 1'b0;
            end
         end else begin
            if (last) begin
               set_done   = 1'b1;
               s_next.cur = 2'b00;
            end else begin
               s_next.cur = s_reg.cur + 2'b01;
            end
            s_next.first  = 1'b0;
            tmr_load      = 1'b1;
            s_next.sample = 1'b1;
            tmr_len       = conv_len(s_reg.speed, 1'b1);
         end
      end

      if (start && !i_standby) begin
         s_next.cur    = s_next.sweep ? 2'b00 : last_input(s_next.chan);
         s_next.first  = 1'b1;
         s_next.sample = 1'b1;
         tmr_load      = 1'b1;
         tmr_len       = conv_len(s_next.speed, 1'b0);
      end

      // completion sets win over a same-cycle clear
      if (set_done) begin
         s_next.done_flag = 1'b1;
         s_next.done_seen = 1'b0;
         s_next.ev_status[0] = 1'b1;
      end
      if (end_conv) begin
         s_next.ev_status[1] = 1'b1;
      end
   end

   assign tmr_abort = !s_reg.go && tmr_busy;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   adc_step_timer #(
      .CNT_W(8)
   ) u_timer (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_load  (tmr_load),
      .i_length(tmr_len),
      .i_abort (tmr_abort),
      .o_busy  (tmr_busy),
      .o_done  (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_pready              = 1'b1;
   assign o_pslverr             = i_psel && i_penable && !addr_ok(i_paddr);
   assign o_prdata              = s_reg.rdata;
   assign o_mux_select          = s_reg.cur;
   assign o_sample              = s_reg.sample;
   assign o_conversion_done_irq = s_reg.done_flag && s_reg.irq_en;
   assign o_irq                 = |(s_reg.ev_status & s_reg.ev_mask);
endmodule // adc_control_status_sequencer

// ### verification/adc_control_status_sequencer_chk.sv
// adc_ctrl_chk: port assertions of the converter control block
// assumes it is bound to the top module; one clock domain
`timescale 1ns/1ns
module adc_ctrl_chk (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic        i_standby,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_sample
);
   logic [7:0] gap_reg;
   logic       unm;
   logic       res;
   assign res = (i_paddr[1:0] == 2'h0) && (i_paddr >= 8'h04) && (i_paddr <= 8'h10);
   assign unm = (i_paddr[1:0] != 2'h0) || (i_paddr > 8'h18);
   // cycles since the last conversion start, saturating
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_reg <= 8'hff;
      end else if (o_sample) begin
         gap_reg <= 8'h01;
      end else if (gap_reg != 8'hff) begin
         gap_reg <= gap_reg + 8'h01;
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence acc;
      i_psel && i_penable;
   endsequence
   sequence rd_acc;
      acc ##0 !i_pwrite;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   pready_high_a: assert property (o_pready) else $error("pready low");
   slverr_map_a: assert property (acc |-> o_pslverr == unm) else $error("pslverr wrong");
   slverr_idle_a: assert property (!(i_psel && i_penable) |-> !o_pslverr)
      else $error("pslverr outside access");
   unm_read_a: assert property (rd_acc ##0 unm |-> o_prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   res_align_a: assert property (rd_acc ##0 res |-> o_prdata[5:0] == 6'h00
      && o_prdata[31:16] == 16'h0000) else $error("result misplaced");
   csr_upper_a: assert property (rd_acc ##0 (i_paddr == 8'h00) |-> o_prdata[31:8] == 24'h00_0000)
      else $error("csr upper bits set");
   sample_pulse_a: assert property (o_sample |=> !o_sample) else $error("sample too long");
   sample_gap_a: assert property (o_sample |-> gap_reg >= 8'h42)
      else $error("conversion too short");
   standby_stop_a: assert property (i_standby ##1 i_standby |-> !o_sample)
      else $error("conversion during standby");
endmodule // adc_ctrl_chk

bind adc_control_status_sequencer adc_ctrl_chk u_chk (.i_clk, .i_rst, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .i_standby, .o_prdata, .o_pready, .o_pslverr, .o_sample);

// ### verification/adc_conv_model.sv
// adc_conv_model: converter core stand-in, code names the input being converted
// assumes the mux select holds for the whole conversion
`timescale 1ns/1ns
module adc_conv_model (
   input  wire logic [1:0] i_mux_select,
   input  wire logic [7:0] i_bias,
   output logic      [9:0] o_conv_data
);
   assign o_conv_data = {i_mux_select, i_bias};
endmodule // adc_conv_model

// ### verification/adc_control_status_sequencer_tb_top.sv
// adc_control_status_sequencer_tb_top: apb scenarios for the converter control block
// assumes zero-wait apb answers and the converter model on the far side
`timescale 1ns/1ns
module adc_control_status_sequencer_tb_top;
   logic        i_clk;
   logic        i_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [7:0]  bias;
   logic        standby;
   logic [9:0]  conv_data;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  mux;
   logic        sample;
   logic        done_irq;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  v;
   int          failures = 0;
   int          compares = 0;
   int          cyc = 0;
   int          nsmp = 0;
   int          t0;
   int          n0;
   int          len;
   adc_control_status_sequencer u_dut (.i_clk, .i_rst, .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_conv_data(conv_data),
      .i_standby(standby), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_mux_select(mux), .o_sample(sample), .o_conversion_done_irq(done_irq), .o_irq(irq));
   adc_conv_model u_model (.i_mux_select(mux), .i_bias(bias), .o_conv_data(conv_data));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc  <= cyc + 1;
      nsmp <= nsmp + (sample === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (e !== g) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge i_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge i_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         final_report();
      end else begin
         rd = prdata;
         err = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, e, rd);
   endtask
   // polls the sticky done event, then clears it
   task automatic wait_ev();
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h14, 8'h00);
         n++;
      end while (rd[0] !== 1'b1 && n < 900);
      chk("ev_seen", 1'b1, rd[0]);
      if (rd[0] !== 1'b1) begin
         final_report();
      end else begin
         chk("irq_set", 1'b1, irq);
         apb(1'b1, 8'h14, 8'h03);
         @(posedge i_clk);
         chk("irq_clr", 1'b0, irq);
      end
   endtask
   task automatic span(input int lo, input int hi);
      chk("span", 1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_rst   = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      bias    = 8'h00;
      standby = 1'b0;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 7; a++) rdc("reset_val", 8'(a * 4), 8'h00);
      rdc("unmapped", 8'h1c, 8'h00);
      chk("slverr", 1'b1, err);
      apb(1'b1, 8'h18, 8'h01);
      for (int k = 0; k < 4; k++) begin
         bias <= 8'h30 + 8'(k);
         len = (k == 0) ? 134 : 70;
         v = 8'h60 + ((k == 0) ? 8'h00 : 8'h08) + 8'(k);
         apb(1'b1, 8'h00, v);
         t0 = cyc;
         wait_ev();
         span(len - 2, len + 10);
         chk("done_irq", 1'b1, done_irq);
         apb(1'b1, 8'h00, v ^ 8'h20);
         rdc("csr_done", 8'h00, v ^ 8'ha0);
         apb(1'b1, 8'h00, v ^ 8'h20);
         rdc("csr_clr", 8'h00, v ^ 8'h20);
         chk("irq_off", 1'b0, done_irq);
         apb(1'b1, 8'h00, v ^ 8'ha0);
         rdc("csr_w1", 8'h00, v ^ 8'h20);
         rdc("result", 8'(k * 4 + 4), {2'(k), 8'h30 + 8'(k), 6'h00});
      end
      n0 = nsmp;
      repeat (150) @(posedge i_clk);
      chk("idle", n0, nsmp);
      bias <= 8'h5a;
      apb(1'b1, 8'h00, 8'h1b);
      apb(1'b1, 8'h00, 8'h3b);
      t0 = cyc;
      wait_ev();
      span(266, 282);
      chk("irq_masked", 1'b0, done_irq);
      for (int k = 0; k < 4; k++) rdc("sweep_res", 8'(k * 4 + 4), {2'(k), 8'h5a, 6'h00});
      rdc("csr_sweep", 8'h00, 8'hbb);
      bias <= 8'ha7;
      apb(1'b1, 8'h00, 8'h3b);
      wait_ev();
      t0 = cyc;
      wait_ev();
      span(250, 272);
      for (int k = 0; k < 4; k++) rdc("repeat_res", 8'(k * 4 + 4), {2'(k), 8'ha7, 6'h00});
      standby <= 1'b1;
      repeat (2) @(posedge i_clk);
      standby <= 1'b0;
      n0 = nsmp;
      repeat (150) @(posedge i_clk);
      chk("stopped", n0, nsmp);
      apb(1'b0, 8'h00, 8'h00);
      chk("go_stby", 1'b0, rd[5]);
      final_report();
   end
endmodule // adc_control_status_sequencer_tb_top
